// ===== core/usb_ep_pkg.sv
// shared constants for the low-speed endpoint engine
package usb_ep_pkg;
  localparam logic [7:0] ADDR_CTRL_EP_TX_CONFIG  = 8'h10;
  localparam logic [7:0] ADDR_DATA_EP_TX_CONFIG  = 8'h11;
  localparam logic [7:0] ADDR_DEV     = 8'h12;
  localparam logic [7:0] ADDR_SCR     = 8'h13;
  localparam logic [7:0] ADDR_CTRL_EP_RX_STATUS  = 8'h14;
  localparam logic [6:0] EP0_BUF_BASE = 7'h70;
  localparam logic [6:0] EP1_BUF_BASE = 7'h78;
  localparam int         BUF_BYTES    = 8;
  localparam logic [3:0] CRC_BYTES    = 4'h2;
  localparam logic [3:0] MAX_RX_COUNT = 4'ha;
  // tx config fields
  localparam int TX_IN_EN  = 7;
  localparam int TX_DATA1  = 6;
  localparam int TX_STALL  = 5;
  localparam int TX_ERR    = 4;
  localparam int TX_EP1_EN = 4;
  // status/control fields
  localparam int SCR_ACTIVE  = 0;
  localparam int SCR_DRIVE_K = 1;
  localparam int SCR_DRIVE_J = 2;
  localparam int SCR_SAO     = 3;
  localparam int SCR_ENR     = 4;
  // rx status fields
  localparam int RX_SETUP  = 0;
  localparam int RX_OUT    = 1;
  localparam int RX_IN     = 2;
  localparam int RX_TOGGLE = 3;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  typedef enum logic [1:0] {TOK_SETUP = 2'h0, TOK_OUT = 2'h1, TOK_IN = 2'h2} tok_t;
  typedef enum logic [1:0] {HS_ACK = 2'h0, HS_NAK = 2'h1, HS_STALL = 2'h2} hs_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_DATA = 2'h1, ST_INACK = 2'h3} state_t;
endpackage : usb_ep_pkg

// ===== core/line_sync.sv
// two-flop synchroniser for the raw bus line levels
`timescale 1ns/1ns
`default_nettype none
module line_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_t;
  sync_t s;
  sync_t next_s;
  always_comb begin
    next_s.meta = i_async;
    next_s.sync = s.meta;
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign o_sync = s.sync;
endmodule : line_sync
`default_nettype wire

// ===== core/usb_ep_engine.sv
// endpoint engine: token handling, handshakes, endpoint registers
`timescale 1ns/1ns
`default_nettype none
module usb_ep_engine (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_io_addr,
  input  wire logic [7:0] i_io_wdata,
  input  wire logic       i_io_wr,
  input  wire logic       i_io_rd,
  output logic      [7:0] o_io_rdata,
  input  wire logic       i_tok_valid,
  input  wire logic [1:0] i_tok_kind,
  input  wire logic [6:0] i_tok_addr,
  input  wire logic [3:0] i_tok_ep,
  input  wire logic       i_rx_byte_valid,
  input  wire logic [7:0] i_rx_byte,
  input  wire logic       i_rx_end,
  input  wire logic       i_rx_err,
  input  wire logic       i_rx_data1,
  input  wire logic       i_hs_ack,
  output logic            o_hs_valid,
  output logic      [1:0] o_hs_code,
  output logic            o_tx_start,
  output logic            o_tx_ep1,
  output logic            o_tx_data1,
  output logic      [3:0] o_tx_count,
  output logic            o_mem_we,
  output logic      [6:0] o_mem_addr,
  output logic      [7:0] o_mem_wdata,
  output logic            o_fifo_wr_block,
  input  wire logic       i_ep0_irq_en,
  input  wire logic       i_ep1_irq_en,
  output logic            o_ep0_irq,
  output logic            o_ep1_irq,
  input  wire logic       i_dp,
  input  wire logic       i_dm,
  output logic            o_force_k,
  output logic            o_force_j
);
  typedef struct packed {
    logic [7:0]            ctrl_ep_tx_config;
    logic [7:0]            data_ep_tx_config;
    logic [6:0]            dev_addr;
    logic [4:0]            scr;
    logic [7:0]            rx_stat;
    usb_ep_pkg::state_t    fsm;
    logic                  m_setup;
    logic                  m_ep1;
    logic                  m_stall;
    logic                  m_sao;
    logic                  m_enr;
    logic [3:0]            cnt;
    logic                  in_ep1;
    logic                  irq0_pend;
    logic                  hs_valid;
    logic [1:0]            hs_code;
    logic                  tx_start;
    logic                  tx_ep1;
    logic                  tx_data1;
    logic [3:0]            tx_count;
    logic                  mem_we;
    logic [6:0]            mem_addr;
    logic [7:0]            mem_wdata;
    logic                  irq0;
    logic                  irq1;
    logic [7:0]            rdata;
  } eng_t;
  eng_t s;
  eng_t next_s;
  logic [1:0] line;
  logic       hit;
  logic       ep0_hit;
  logic       ep1_hit;
  logic       store;
  logic       bad;

  // dm enters inverted so the synchroniser's reset value reads as idle
  line_sync #(.WIDTH(2)) u_sync (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_async({i_dp, !i_dm}),
    .o_sync (line)
  );

  always_comb begin
    hit     = i_tok_valid && (i_tok_addr == s.dev_addr);
    ep0_hit = hit && (i_tok_ep == 4'h0);
    ep1_hit = hit && (i_tok_ep == 4'h1) && s.data_ep_tx_config[usb_ep_pkg::TX_EP1_EN];
    store   = s.m_setup || (s.m_enr && !s.m_stall && !s.m_sao);
    bad     = i_rx_err || (s.cnt > usb_ep_pkg::MAX_RX_COUNT);
  end

  always_comb begin
    next_s           = s;
    next_s.hs_valid  = 1'b0;
    next_s.tx_start  = 1'b0;
    next_s.mem_we    = 1'b0;
    next_s.irq0      = 1'b0;
    next_s.irq1      = 1'b0;
    next_s.irq0_pend = 1'b0;
    // firmware side first so hardware events below win
    if (i_io_rd) begin
      case (i_io_addr)
        usb_ep_pkg::ADDR_CTRL_EP_TX_CONFIG: next_s.rdata = s.ctrl_ep_tx_config;
        usb_ep_pkg::ADDR_DATA_EP_TX_CONFIG: next_s.rdata = s.data_ep_tx_config;
        usb_ep_pkg::ADDR_DEV:    next_s.rdata = {1'b0, s.dev_addr};
        usb_ep_pkg::ADDR_SCR:    next_s.rdata = {3'h0, s.scr};
        usb_ep_pkg::ADDR_CTRL_EP_RX_STATUS: next_s.rdata = s.rx_stat;
        default:                 next_s.rdata = usb_ep_pkg::RESET_VALUE;
      endcase
    end
    if (i_io_wr) begin
      case (i_io_addr)
        usb_ep_pkg::ADDR_CTRL_EP_TX_CONFIG: next_s.ctrl_ep_tx_config = i_io_wdata;
        usb_ep_pkg::ADDR_DATA_EP_TX_CONFIG: next_s.data_ep_tx_config = i_io_wdata;
        usb_ep_pkg::ADDR_DEV:    next_s.dev_addr = i_io_wdata[6:0];
        usb_ep_pkg::ADDR_SCR: begin
          next_s.scr[4:1] = i_io_wdata[4:1];
          next_s.scr[0]   = s.scr[0] && i_io_wdata[0];
        end
        usb_ep_pkg::ADDR_CTRL_EP_RX_STATUS: begin
          next_s.rx_stat = {4'h0, s.rx_stat[usb_ep_pkg::RX_TOGGLE], 3'h0};
          // setup data still arriving keeps the flag
          if (s.fsm == usb_ep_pkg::ST_DATA && s.m_setup) begin
            next_s.rx_stat[usb_ep_pkg::RX_SETUP] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (line != 2'b00) begin
      next_s.scr[usb_ep_pkg::SCR_ACTIVE] = 1'b1;
    end
    if (s.irq0_pend) begin
      next_s.irq0 = i_ep0_irq_en;
    end
    case (s.fsm)
      usb_ep_pkg::ST_DATA: begin
        if (i_rx_byte_valid) begin
          if (s.cnt != 4'hf) begin
            next_s.cnt = s.cnt + 4'h1;
          end
          if (store && !s.m_ep1 && s.cnt < 4'(usb_ep_pkg::BUF_BYTES)) begin
            next_s.mem_we    = 1'b1;
            next_s.mem_addr  = usb_ep_pkg::EP0_BUF_BASE + {4'h0, s.cnt[2:0]};
            next_s.mem_wdata = i_rx_byte;
          end
        end
        if (i_rx_end) begin
          next_s.fsm = usb_ep_pkg::ST_IDLE;
          if (s.m_ep1) begin
            if (s.m_stall && !bad) begin
              next_s.hs_valid = 1'b1;
              next_s.hs_code  = usb_ep_pkg::HS_STALL;
            end
          end else begin
            if (bad) begin
              next_s.ctrl_ep_tx_config[usb_ep_pkg::TX_ERR] = 1'b1;
            end
            if (s.m_setup || (!s.m_stall && (s.m_enr || s.m_sao))) begin
              next_s.rx_stat[usb_ep_pkg::RX_TOGGLE] = i_rx_data1;
            end
            if (s.m_setup || (!s.m_stall && (s.m_enr || (s.m_sao && !bad)))) begin
              next_s.rx_stat[7:4] = s.cnt;
              next_s.irq0_pend    = 1'b1;
            end
            next_s.hs_valid = !bad;
            // stall outranks the receive enables so a stalled OUT never gets ACK
            if (s.m_setup) begin
              next_s.hs_code = usb_ep_pkg::HS_ACK;
            end else if (s.m_stall) begin
              next_s.hs_code = usb_ep_pkg::HS_STALL;
            end else if (s.m_sao) begin
              next_s.hs_code = (i_rx_data1 && s.cnt == usb_ep_pkg::CRC_BYTES)
                             ? usb_ep_pkg::HS_ACK : usb_ep_pkg::HS_STALL;
            end else if (s.m_enr) begin
              next_s.hs_code = usb_ep_pkg::HS_ACK;
              if (!bad) begin
                next_s.scr[usb_ep_pkg::SCR_ENR] = 1'b0;
              end
            end else begin
              next_s.hs_code = usb_ep_pkg::HS_NAK;
            end
          end
        end
      end
      usb_ep_pkg::ST_INACK: begin
        if (i_hs_ack) begin
          next_s.fsm = usb_ep_pkg::ST_IDLE;
          if (s.in_ep1) begin
            next_s.data_ep_tx_config[usb_ep_pkg::TX_IN_EN] = 1'b0;
            next_s.irq1 = i_ep1_irq_en;
          end else begin
            next_s.ctrl_ep_tx_config[usb_ep_pkg::TX_IN_EN] = 1'b0;
            next_s.irq0 = i_ep0_irq_en;
          end
        end else if (i_tok_valid) begin
          next_s.fsm = usb_ep_pkg::ST_IDLE; // host gave up; no ack came
        end
      end
      usb_ep_pkg::ST_IDLE: ;
      default: next_s.fsm = usb_ep_pkg::ST_IDLE;
    endcase
    // a token for endpoint 0, or for endpoint 1 when enabled, restarts the transaction; any other token drops to idle
    if (ep0_hit) begin
      next_s.rx_stat[usb_ep_pkg::RX_OUT] = (i_tok_kind == usb_ep_pkg::TOK_OUT);
      next_s.rx_stat[usb_ep_pkg::RX_IN]  = (i_tok_kind == usb_ep_pkg::TOK_IN);
      next_s.m_ep1   = 1'b0;
      next_s.m_setup = (i_tok_kind == usb_ep_pkg::TOK_SETUP);
      next_s.m_stall = s.ctrl_ep_tx_config[usb_ep_pkg::TX_STALL];
      next_s.m_sao   = s.scr[usb_ep_pkg::SCR_SAO];
      next_s.m_enr   = s.scr[usb_ep_pkg::SCR_ENR];
      next_s.cnt     = 4'h0;
      if (i_tok_kind == usb_ep_pkg::TOK_SETUP) begin
        next_s.rx_stat[usb_ep_pkg::RX_SETUP] = 1'b1;
        next_s.ctrl_ep_tx_config[usb_ep_pkg::TX_STALL] = 1'b0;
        next_s.ctrl_ep_tx_config[usb_ep_pkg::TX_IN_EN] = 1'b0;
        next_s.scr[usb_ep_pkg::SCR_SAO]     = 1'b0;
        next_s.scr[usb_ep_pkg::SCR_ENR]     = 1'b0;
        next_s.fsm = usb_ep_pkg::ST_DATA;
      end else if (i_tok_kind == usb_ep_pkg::TOK_OUT) begin
        next_s.fsm = usb_ep_pkg::ST_DATA;
      end else begin
        next_s.fsm      = usb_ep_pkg::ST_IDLE;
        next_s.hs_valid = 1'b1;
        if (s.ctrl_ep_tx_config[usb_ep_pkg::TX_STALL]) begin
          next_s.hs_code = usb_ep_pkg::HS_STALL;
        end else if (s.ctrl_ep_tx_config[usb_ep_pkg::TX_IN_EN]) begin
          next_s.hs_valid = 1'b0;
          next_s.tx_start = 1'b1;
          next_s.tx_ep1   = 1'b0;
          next_s.tx_data1 = s.ctrl_ep_tx_config[usb_ep_pkg::TX_DATA1];
          next_s.tx_count = s.ctrl_ep_tx_config[3:0];
          next_s.in_ep1   = 1'b0;
          next_s.fsm      = usb_ep_pkg::ST_INACK;
        end else begin
          next_s.hs_code = usb_ep_pkg::HS_NAK;
        end
      end
    end else if (ep1_hit) begin
      next_s.m_ep1   = 1'b1;
      next_s.m_setup = 1'b0;
      next_s.m_stall = s.data_ep_tx_config[usb_ep_pkg::TX_STALL];
      next_s.cnt     = 4'h0;
      next_s.fsm     = usb_ep_pkg::ST_IDLE;
      if (i_tok_kind == usb_ep_pkg::TOK_IN) begin
        next_s.hs_valid = 1'b1;
        if (s.data_ep_tx_config[usb_ep_pkg::TX_STALL]) begin
          next_s.hs_code = usb_ep_pkg::HS_STALL;
        end else if (s.data_ep_tx_config[usb_ep_pkg::TX_IN_EN]) begin
          next_s.hs_valid = 1'b0;
          next_s.tx_start = 1'b1;
          next_s.tx_ep1   = 1'b1;
          next_s.tx_data1 = s.data_ep_tx_config[usb_ep_pkg::TX_DATA1];
          next_s.tx_count = s.data_ep_tx_config[3:0];
          next_s.in_ep1   = 1'b1;
          next_s.fsm      = usb_ep_pkg::ST_INACK;
        end else begin
          next_s.hs_code = usb_ep_pkg::HS_NAK;
        end
      end else begin
        // data after OUT/SETUP is swallowed, only a stall replies
        next_s.fsm = usb_ep_pkg::ST_DATA;
      end
    end else if (i_tok_valid) begin
      next_s.fsm = usb_ep_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s     <= '0;
      s.fsm <= usb_ep_pkg::ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign o_io_rdata      = s.rdata;
  assign o_hs_valid      = s.hs_valid;
  assign o_hs_code       = s.hs_code;
  assign o_tx_start      = s.tx_start;
  assign o_tx_ep1        = s.tx_ep1;
  assign o_tx_data1      = s.tx_data1;
  assign o_tx_count      = s.tx_count;
  assign o_mem_we        = s.mem_we;
  assign o_mem_addr      = s.mem_addr;
  assign o_mem_wdata     = s.mem_wdata;
  assign o_fifo_wr_block = s.rx_stat[usb_ep_pkg::RX_SETUP];
  assign o_ep0_irq       = s.irq0;
  assign o_ep1_irq       = s.irq1;
  assign o_force_k       = s.scr[usb_ep_pkg::SCR_DRIVE_K];
  assign o_force_j       = s.scr[usb_ep_pkg::SCR_DRIVE_J];

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_setup_flag;
    ep0_hit && i_tok_kind == usb_ep_pkg::TOK_SETUP
      |=> s.rx_stat[0] && !s.ctrl_ep_tx_config[7] && !s.ctrl_ep_tx_config[5] && !s.scr[4];
  endproperty
  a_setup_flag: assert property (p_setup_flag) else $error("setup side effects missing");
  property p_rx_write;
    i_io_wr && i_io_addr == 8'h14 && s.fsm == usb_ep_pkg::ST_IDLE && !i_tok_valid
      |=> s.rx_stat[7:4] == 4'h0 && s.rx_stat[2:0] == 3'h0
          && s.rx_stat[3] == $past(s.rx_stat[3]);
  endproperty
  a_rx_write: assert property (p_rx_write) else $error("rx status write wrong");
  property p_ep0_stall_in;
    ep0_hit && i_tok_kind == usb_ep_pkg::TOK_IN && s.ctrl_ep_tx_config[5]
      |=> s.hs_valid && s.hs_code == usb_ep_pkg::HS_STALL && !s.tx_start;
  endproperty
  a_ep0_stall_in: assert property (p_ep0_stall_in) else $error("no stall on IN");
  property p_in_ack;
    s.fsm == usb_ep_pkg::ST_INACK && !s.in_ep1 && i_hs_ack && i_ep0_irq_en
      |=> !s.ctrl_ep_tx_config[7] && s.irq0;
  endproperty
  a_in_ack: assert property (p_in_ack) else $error("IN ack not handled");
  property p_nak_out;
    s.fsm == usb_ep_pkg::ST_DATA && i_rx_end && !s.m_setup && !s.m_ep1
      && !s.m_stall && !s.m_sao && !s.m_enr && !bad
      |=> s.hs_valid && s.hs_code == usb_ep_pkg::HS_NAK ##1 !s.irq0;
  endproperty
  a_nak_out: assert property (p_nak_out) else $error("OUT not NAKed");
  property p_buf_range;
    s.mem_we |-> s.mem_addr[6:3] == 4'he;
  endproperty
  a_buf_range: assert property (p_buf_range) else $error("buffer write out of range");
  property p_ep1_off;
    i_tok_valid && i_tok_ep == 4'h1 && !s.data_ep_tx_config[4]
      |=> !s.hs_valid && !s.tx_start;
  endproperty
  a_ep1_off: assert property (p_ep1_off) else $error("disabled endpoint answered");
  property p_status_first;
    s.fsm == usb_ep_pkg::ST_DATA && i_rx_end && s.m_setup && i_ep0_irq_en
      |=> s.rx_stat[7:4] == $past(s.cnt) && !s.irq0 ##1 s.irq0;
  endproperty
  a_status_first: assert property (p_status_first) else $error("irq before status");
  property p_activity_keep;
    s.scr[0] && i_io_wr && i_io_addr == 8'h13 && i_io_wdata[0] |=> s.scr[0];
  endproperty
  a_activity_keep: assert property (p_activity_keep) else $error("activity flag lost");
  c_setup: cover property (ep0_hit && i_tok_kind == usb_ep_pkg::TOK_SETUP ##[1:40] s.irq0);
  c_in_ep1: cover property (s.tx_start && s.tx_ep1 ##[1:40] s.irq1);
  c_status_ack: cover property (s.m_sao && s.hs_valid && s.hs_code == usb_ep_pkg::HS_ACK);
endmodule : usb_ep_engine
`default_nettype wire

// ===== verif/usb_host_model.sv
// low-speed host model driving the engine's token, data and line sideband
`timescale 1ns/1ns
`default_nettype none
module usb_host_model (
  input  wire logic       i_mclk,
  output logic            o_tok_valid,
  output logic      [1:0] o_tok_kind,
  output logic      [6:0] o_tok_addr,
  output logic      [3:0] o_tok_ep,
  output logic            o_rx_byte_valid,
  output logic      [7:0] o_rx_byte,
  output logic            o_rx_end,
  output logic            o_rx_err,
  output logic            o_rx_data1,
  output logic            o_hs_ack,
  output logic            o_dp,
  output logic            o_dm
);
  initial begin
    {o_tok_valid, o_tok_kind, o_tok_addr, o_tok_ep} = '0;
    {o_rx_byte_valid, o_rx_byte, o_rx_end, o_rx_err, o_rx_data1, o_hs_ack} = '0;
    o_dp = 1'b0;
    o_dm = 1'b1;
  end

  task automatic token(input logic [1:0] k, input logic [6:0] a, input logic [3:0] ep);
    @(posedge i_mclk);
    o_tok_valid <= 1'b1;
    o_tok_kind  <= k;
    o_tok_addr  <= a;
    o_tok_ep    <= ep;
    @(posedge i_mclk);
    o_tok_valid <= 1'b0;
    o_tok_addr  <= ~a;
    o_tok_ep    <= ~ep;
  endtask : token

  // n data bytes then two crc bytes; err marks the packet as damaged
  task automatic packet(input int n, input logic [7:0] f, input logic d1, input logic err);
    logic [7:0] b;
    for (int i = 0; i < n + 2; i++) begin
      b = (i < n) ? f + 8'(i) : ((i == n) ? 8'h3c : 8'hc3);
      @(posedge i_mclk);
      o_rx_byte_valid <= 1'b1;
      o_rx_byte       <= b;
      @(posedge i_mclk);
      o_rx_byte_valid <= 1'b0;
      // stale data is inverted so nothing can lean on it
      o_rx_byte       <= ~b;
    end
    @(posedge i_mclk);
    o_rx_end   <= 1'b1;
    o_rx_err   <= err;
    o_rx_data1 <= d1;
    @(posedge i_mclk);
    o_rx_end   <= 1'b0;
    o_rx_err   <= ~err;
    o_rx_data1 <= ~d1;
  endtask : packet

  task automatic ack();
    @(posedge i_mclk);
    o_hs_ack <= 1'b1;
    @(posedge i_mclk);
    o_hs_ack <= 1'b0;
  endtask : ack

  task automatic line(input logic dp, input logic dm);
    @(posedge i_mclk);
    o_dp <= dp;
    o_dm <= dm;
  endtask : line
endmodule : usb_host_model
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the endpoint engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_mclk, i_rst, i_io_wr, i_io_rd, i_tok_valid, i_rx_byte_valid, i_rx_end;
  logic i_rx_err, i_rx_data1, i_hs_ack, i_ep0_irq_en, i_ep1_irq_en, i_dp, i_dm;
  logic [7:0] i_io_addr, i_io_wdata, o_io_rdata, i_rx_byte, o_mem_wdata;
  logic [1:0] i_tok_kind, o_hs_code;
  logic [6:0] i_tok_addr, o_mem_addr;
  logic [3:0] i_tok_ep, o_tx_count;
  logic o_hs_valid, o_tx_start, o_tx_ep1, o_tx_data1, o_mem_we, o_fifo_wr_block;
  logic o_ep0_irq, o_ep1_irq, o_force_k, o_force_j;
  int num_errors = 0;
  int n_tests = 0;
  int hs_n = 0, irq0_n = 0, irq1_n = 0, we_n = 0, tx_n = 0;
  logic [1:0] hs_last;
  logic [7:0] mem [0:127];
  logic [7:0] regs [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};

  usb_ep_engine usb_ep_engine_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_io_addr(i_io_addr),
    .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata),
    .i_tok_valid(i_tok_valid), .i_tok_kind(i_tok_kind), .i_tok_addr(i_tok_addr),
    .i_tok_ep(i_tok_ep), .i_rx_byte_valid(i_rx_byte_valid), .i_rx_byte(i_rx_byte),
    .i_rx_end(i_rx_end), .i_rx_err(i_rx_err), .i_rx_data1(i_rx_data1), .i_hs_ack(i_hs_ack),
    .o_hs_valid(o_hs_valid), .o_hs_code(o_hs_code), .o_tx_start(o_tx_start),
    .o_tx_ep1(o_tx_ep1), .o_tx_data1(o_tx_data1), .o_tx_count(o_tx_count),
    .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_fifo_wr_block(o_fifo_wr_block), .i_ep0_irq_en(i_ep0_irq_en),
    .i_ep1_irq_en(i_ep1_irq_en), .o_ep0_irq(o_ep0_irq), .o_ep1_irq(o_ep1_irq),
    .i_dp(i_dp), .i_dm(i_dm), .o_force_k(o_force_k), .o_force_j(o_force_j));

  usb_host_model usb_host_model_i (.i_mclk(i_mclk), .o_tok_valid(i_tok_valid),
    .o_tok_kind(i_tok_kind), .o_tok_addr(i_tok_addr), .o_tok_ep(i_tok_ep),
    .o_rx_byte_valid(i_rx_byte_valid), .o_rx_byte(i_rx_byte), .o_rx_end(i_rx_end),
    .o_rx_err(i_rx_err), .o_rx_data1(i_rx_data1), .o_hs_ack(i_hs_ack), .o_dp(i_dp),
    .o_dm(i_dm));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    hs_n   += int'(o_hs_valid === 1'b1);
    irq0_n += int'(o_ep0_irq === 1'b1);
    irq1_n += int'(o_ep1_irq === 1'b1);
    tx_n   += int'(o_tx_start === 1'b1);
    we_n   += int'(o_mem_we === 1'b1);
    if (o_hs_valid === 1'b1)
      hs_last = o_hs_code;
    if (o_mem_we === 1'b1)
      mem[o_mem_addr] = o_mem_wdata;
  end

  task automatic results();
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_io_wr    <= 1'b1;
    i_io_addr  <= a;
    i_io_wdata <= d;
    @(posedge i_mclk);
    i_io_wr    <= 1'b0;
    i_io_wdata <= ~d;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge i_mclk);
    i_io_rd   <= 1'b1;
    i_io_addr <= a;
    @(posedge i_mclk);
    i_io_rd <= 1'b0;
    @(posedge i_mclk);
    #1;
    chk(name, o_io_rdata, exp);
  endtask : rdc

  // replies land within two cycles, so six idle cycles close the window
  task automatic mon(input int hs, input logic [1:0] c, input int i0, input int i1,
                     input int we, input int tx);
    repeat (6) @(posedge i_mclk);
    #1;
    chk("handshakes", 8'(hs_n), 8'(hs));
    if (hs > 0)
      chk("hs_code", {6'h0, hs_last}, {6'h0, c});
    chk("ep0_irq", 8'(irq0_n), 8'(i0));
    chk("ep1_irq", 8'(irq1_n), 8'(i1));
    chk("mem_writes", 8'(we_n), 8'(we));
    chk("tx_starts", 8'(tx_n), 8'(tx));
    {hs_n, irq0_n, irq1_n, we_n, tx_n} = '0;
  endtask : mon

  task automatic out_pkt(input int n, input logic [7:0] f, input logic d1, input logic e);
    usb_host_model_i.token(usb_ep_pkg::TOK_OUT, 7'h00, 4'h0);
    usb_host_model_i.packet(n, f, d1, e);
  endtask : out_pkt

  task automatic in_tok(input logic [3:0] ep);
    usb_host_model_i.token(usb_ep_pkg::TOK_IN, 7'h00, ep);
  endtask : in_tok

  initial begin
    repeat (50000) @(posedge i_mclk);
    num_errors++;
    results();
  end

  initial begin
    {i_rst, i_io_wr, i_io_rd, i_ep0_irq_en, i_ep1_irq_en} = 5'h13;
    {i_io_addr, i_io_wdata} = '0;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    foreach (regs[i]) rdc(regs[i], 8'h00, "reset_value");
    wr(8'h10, 8'ha5);
    wr(8'h13, 8'h18);
    usb_host_model_i.token(usb_ep_pkg::TOK_SETUP, 7'h00, 4'h0);
    @(posedge i_mclk);
    #1;
    chk("fifo_block", {7'h0, o_fifo_wr_block}, 8'h01);
    usb_host_model_i.packet(8, 8'h40, 1'b0, 1'b0);
    mon(1, usb_ep_pkg::HS_ACK, 1, 0, 8, 0);
    chk("fifo_last", mem[7'h77], 8'h47);
    rdc(8'h14, 8'ha1, "rx_status");
    rdc(8'h10, 8'h05, "ctrl_ep_tx_config_after_setup");
    rdc(8'h13, 8'h00, "scr_after_setup");
    wr(8'h14, 8'hff);
    rdc(8'h14, 8'h00, "rx_cleared");
    // a write during the data phase must not drop the setup flag
    usb_host_model_i.token(usb_ep_pkg::TOK_SETUP, 7'h00, 4'h0);
    wr(8'h14, 8'h00);
    usb_host_model_i.packet(9, 8'h50, 1'b1, 1'b0);
    mon(0, usb_ep_pkg::HS_ACK, 1, 0, 8, 0);
    chk("fifo_cap", mem[7'h77], 8'h57);
    rdc(8'h14, 8'hb9, "rx_long");
    rdc(8'h10, 8'h15, "rx_error_flag");
    wr(8'h14, 8'h00);
    rdc(8'h14, 8'h08, "toggle_kept");
    wr(8'h10, 8'h00);
    usb_host_model_i.token(usb_ep_pkg::TOK_SETUP, 7'h00, 4'h0);
    usb_host_model_i.packet(3, 8'h60, 1'b0, 1'b0);
    mon(1, usb_ep_pkg::HS_ACK, 1, 0, 5, 0);
    chk("crc_stored", mem[7'h74], 8'hc3);
    out_pkt(2, 8'h80, 1'b1, 1'b0);
    mon(1, usb_ep_pkg::HS_NAK, 0, 0, 0, 0);
    rdc(8'h14, 8'h53, "rx_after_nak");
    out_pkt(2, 8'h80, 1'b1, 1'b1);
    mon(0, usb_ep_pkg::HS_NAK, 0, 0, 0, 0);
    wr(8'h14, 8'h00);
    wr(8'h13, 8'h10);
    out_pkt(4, 8'h90, 1'b1, 1'b0);
    mon(1, usb_ep_pkg::HS_ACK, 1, 0, 6, 0);
    chk("out_data", mem[7'h70], 8'h90);
    rdc(8'h14, 8'h6a, "rx_out");
    rdc(8'h13, 8'h00, "enable_cleared");
    wr(8'h13, 8'h10);
    wr(8'h10, 8'h00);
    out_pkt(1, 8'ha0, 1'b0, 1'b1);
    mon(0, usb_ep_pkg::HS_ACK, 1, 0, 3, 0);
    rdc(8'h14, 8'h32, "rx_out_err");
    rdc(8'h10, 8'h10, "rx_error_out");
    rdc(8'h13, 8'h10, "enable_kept");
    wr(8'h10, 8'h00);
    wr(8'h13, 8'h08);
    out_pkt(0, 8'h00, 1'b1, 1'b0);
    mon(1, usb_ep_pkg::HS_ACK, 1, 0, 0, 0);
    rdc(8'h14, 8'h2a, "status_ack");
    out_pkt(1, 8'hb0, 1'b0, 1'b0);
    mon(1, usb_ep_pkg::HS_STALL, 1, 0, 0, 0);
    out_pkt(0, 8'h00, 1'b1, 1'b1);
    mon(0, usb_ep_pkg::HS_ACK, 0, 0, 0, 0);
    rdc(8'h14, 8'h3a, "status_err_toggle");
    wr(8'h13, 8'h00);
    wr(8'h10, 8'h20);
    out_pkt(1, 8'hc0, 1'b0, 1'b0);
    in_tok(4'h0);
    mon(2, usb_ep_pkg::HS_STALL, 0, 0, 0, 0);
    wr(8'h10, 8'h00);
    in_tok(4'h0);
    mon(1, usb_ep_pkg::HS_NAK, 0, 0, 0, 0);
    wr(8'h10, 8'hc3);
    in_tok(4'h0);
    mon(0, usb_ep_pkg::HS_NAK, 0, 0, 0, 1);
    chk("tx0_fields", {o_tx_ep1, o_tx_data1, 2'h0, o_tx_count}, 8'h43);
    rdc(8'h14, 8'h3c, "in_flag");
    usb_host_model_i.ack();
    mon(0, usb_ep_pkg::HS_NAK, 1, 0, 0, 0);
    rdc(8'h10, 8'h43, "ep0_in_done");
    in_tok(4'h1);
    mon(0, usb_ep_pkg::HS_NAK, 0, 0, 0, 0);
    wr(8'h11, 8'h10);
    in_tok(4'h1);
    mon(1, usb_ep_pkg::HS_NAK, 0, 0, 0, 0);
    wr(8'h11, 8'h95);
    in_tok(4'h1);
    mon(0, usb_ep_pkg::HS_NAK, 0, 0, 0, 1);
    chk("tx1_fields", {o_tx_ep1, o_tx_data1, 2'h0, o_tx_count}, 8'h85);
    usb_host_model_i.ack();
    mon(0, usb_ep_pkg::HS_NAK, 0, 1, 0, 0);
    rdc(8'h11, 8'h15, "ep1_in_done");
    wr(8'h11, 8'h30);
    in_tok(4'h1);
    usb_host_model_i.token(usb_ep_pkg::TOK_OUT, 7'h00, 4'h1);
    usb_host_model_i.packet(0, 8'h00, 1'b0, 1'b0);
    mon(2, usb_ep_pkg::HS_STALL, 0, 0, 0, 0);
    wr(8'h11, 8'h10);
    in_tok(4'h1);
    mon(1, usb_ep_pkg::HS_NAK, 0, 0, 0, 0);
    @(posedge i_mclk) i_ep0_irq_en <= 1'b0;
    wr(8'h13, 8'h10);
    out_pkt(1, 8'hd0, 1'b0, 1'b0);
    mon(1, usb_ep_pkg::HS_ACK, 0, 0, 3, 0);
    @(posedge i_mclk) i_ep0_irq_en <= 1'b1;
    wr(8'h12, 8'hff);
    rdc(8'h12, 8'h7f, "dev_addr");
    wr(8'h12, 8'h05);
    in_tok(4'h0);
    mon(0, usb_ep_pkg::HS_NAK, 0, 0, 0, 0);
    usb_host_model_i.token(usb_ep_pkg::TOK_IN, 7'h05, 4'h0);
    mon(1, usb_ep_pkg::HS_NAK, 0, 0, 0, 0);
    usb_host_model_i.line(1'b1, 1'b0);
    repeat (4) @(posedge i_mclk);
    usb_host_model_i.line(1'b0, 1'b1);
    rdc(8'h13, 8'h01, "bus_active");
    wr(8'h13, 8'h01);
    rdc(8'h13, 8'h01, "bus_active_kept");
    wr(8'h13, 8'h06);
    rdc(8'h13, 8'h06, "force_bits");
    chk("force_lines", {6'h0, o_force_j, o_force_k}, 8'h03);
    results();
  end
endmodule : tb_top
`default_nettype wire
